// File: src/nvm_cell_array.sv
// Nonvolatile cell store: 512 bytes plus the configuration byte
`default_nettype none

module nvm_cell_array (
    // Clock
    input wire logic pclk,
    // High voltage operation
    input wire nvm_seq_pkg::nvm_op_type op,
    // Read port
    input wire logic [nvm_seq_pkg::OFS_W-1:0] rd_offset,
    output logic [7:0] rd_data,
    output logic [7:0] config_byte
);
    import nvm_seq_pkg::*;

    // Cells keep their value through reset; erased cells read as ones
    logic [7:0] cells [ARRAY_BYTES] = '{default: ERASED_BYTE};
    logic [7:0] config_cell = CONFIG_INIT;

    // Apply one operation when the high voltage switches on
    always_ff @(posedge pclk) begin
        if (op.start) begin
            unique case (op.mode)
                OP_BYTE_PROGRAM: begin
                    if (op.config_sel) begin
                        config_cell <= config_cell & op.data;
                    end else begin
                        cells[op.offset] <= cells[op.offset] & op.data;
                        if (op.mirror) begin
                            cells[op.offset | 9'h100] <= cells[op.offset] & op.data;
                        end
                    end
                end
                OP_BYTE_ERASE: begin
                    if (op.config_sel) begin
                        config_cell <= ERASED_BYTE;
                    end else begin
                        cells[op.offset] <= ERASED_BYTE;
                        if (op.mirror) begin
                            cells[op.offset | 9'h100] <= ERASED_BYTE;
                        end
                    end
                end
                OP_BLOCK_ERASE: begin
                    for (int i = 0; i < ARRAY_BYTES; i++) begin
                        if (i[BLOCK_MSB:BLOCK_LSB] == op.offset[BLOCK_MSB:BLOCK_LSB]
                            || (op.mirror && i[BLOCK_LSB] == op.offset[BLOCK_LSB])) begin
                            cells[i] <= ERASED_BYTE;
                        end
                    end
                end
                OP_BULK_ERASE: begin
                    for (int i = 0; i < ARRAY_BYTES; i++) begin
                        cells[i] <= ERASED_BYTE;
                    end
                end
            endcase
        end
    end

    // Combinational read of cell and configuration byte
    assign rd_data = cells[rd_offset];
    assign config_byte = config_cell;

endmodule : nvm_cell_array

`default_nettype wire

// File: src/nvm_program_sequencer.sv
// APB slave that sequences byte program and erase of the nonvolatile array
`default_nettype none

// Behaviour
// - Erased bit reads one; program only clears
// - 512 bytes, internal supply only
// - Only unprotected array bytes and config byte
// - Redundant mode mirrors lower half into upper
// - Program only when both erase bits zero
// - Capture bit latches valid array and config byte writes only
// - Later valid write replaces captured address, data
// - Array reads return captured data while capturing
// - Control writes wait for a captured write
// - Enable refused without capture and valid write
// - Enable drives pump and high voltage
// - Clearing both clears only the enable
// - Shadow reloads after reset and config reads
// - Protection per 128-byte block
// - Capture bit stays while enable set
// - Voltage needs enable, capture and captured write
// - Erase bits select mode; protect blocks all
// - Protected target never gets high voltage
module nvm_program_sequencer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nvm_seq_pkg::ADDR_W-1:0] paddr,
    input wire logic [nvm_seq_pkg::DATA_W-1:0] pwdata,
    output logic [nvm_seq_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Charge pump and array control
    output logic high_voltage_on,
    output logic pump_bus_clock,
    output logic array_power_down
);
    import nvm_seq_pkg::*;

    // ========================================================================
    // State
    // Control register and its next value
    nvm_ctrl_type ctrl_reg;
    nvm_ctrl_type ctrl_next;

    // Configuration shadow and its reload flag
    logic [7:0] shadow_reg;
    logic shadow_load_reg;

    // Captured target and data
    logic captured_reg;
    logic [OFS_W-1:0] cap_offset_reg;
    logic cap_config_reg;
    logic [7:0] cap_data_reg;

    // High voltage level and its last value
    logic hv_reg;
    logic hv_next;
    logic hv_prev_reg;

    // Bus answer registers
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;

    // ========================================================================
    // Address decode
    // Word index and offset into the array
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] idx_rel;
    logic [OFS_W-1:0] offset;

    // Fields of the configuration shadow
    logic redundant;
    logic [BLOCKS-1:0] protect;

    // Target classes of the current address
    logic in_array;
    logic valid_array;
    logic is_config;
    logic is_ctrl;
    logic is_shadow;
    logic nvm_target;
    logic mapped;

    // Bus phase qualifiers
    logic setup_phase;
    logic access_done;
    logic bus_write;
    logic bus_read;

    // Word index, array offset and target class
    assign idx = paddr[ADDR_W-1:2];
    assign idx_rel = idx - IDX_ARRAY_FIRST;
    assign offset = idx_rel[OFS_W-1:0];
    assign redundant = shadow_reg[CFG_REDUNDANT_BIT];
    assign protect = shadow_reg[CFG_PROTECT_LSB +: BLOCKS];
    assign in_array = (idx >= IDX_ARRAY_FIRST) && (idx <= IDX_ARRAY_LAST);
    assign valid_array = in_array && !(redundant && offset[HALF_BIT]);
    assign is_config = (idx == IDX_CONFIG);
    assign is_ctrl = (idx == IDX_CTRL);
    assign is_shadow = (idx == IDX_SHADOW);
    assign nvm_target = valid_array || is_config;
    assign mapped = in_array || is_config || is_ctrl || is_shadow;

    // APB phases
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign bus_write = access_done && pwrite;
    assign bus_read = access_done && !pwrite;

    // ========================================================================
    // Cell array
    nvm_op_type op;
    logic [7:0] cell_data;
    logic [7:0] config_byte;

    // Operation handed to the cells on the rising edge of the voltage
    always_comb begin
        op.start = hv_reg && !hv_prev_reg;
        op.mode = op_mode_type'({ctrl_reg.erase_mode_hi, ctrl_reg.erase_mode_lo});
        op.config_sel = cap_config_reg;
        op.mirror = redundant && !cap_offset_reg[HALF_BIT];
        op.offset = cap_offset_reg;
        op.data = cap_data_reg;
    end

    // Cell store; its read port follows the bus offset
    nvm_cell_array cells_u (
        .pclk(pclk),
        .op(op),
        .rd_offset(offset),
        .rd_data(cell_data),
        .config_byte(config_byte)
    );

    // ========================================================================
    // Capture of address and data
    logic capture_write;
    logic ctrl_locked;

    // Captures stop once the enable is set, so the target
    // cannot move under a running high voltage pulse
    // A valid target written while capturing and before the enable is set
    assign capture_write = bus_write && nvm_target && ctrl_reg.bus_capture_bit
                           && !ctrl_reg.high_voltage_enable;
    // Control writes are held off until something was captured
    assign ctrl_locked = ctrl_reg.bus_capture_bit && !captured_reg;

    // Captured flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_reg <= 1'b0;
        end else if (capture_write) begin
            captured_reg <= 1'b1;
        end else if (!ctrl_reg.bus_capture_bit) begin
            captured_reg <= 1'b0;
        end
    end

    // Captured address and data, newest valid write wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_offset_reg <= '0;
            cap_config_reg <= 1'b0;
            cap_data_reg <= 8'h00;
        end else if (capture_write) begin
            cap_offset_reg <= offset;
            cap_config_reg <= is_config;
            cap_data_reg <= pwdata[7:0];
        end
    end

    // ========================================================================
    // Control register
    nvm_ctrl_type wr_ctrl;

    // Written byte viewed as control fields
    assign wr_ctrl = nvm_ctrl_type'(pwdata[7:0]);

    // Next control value from a software write
    always_comb begin
        ctrl_next = ctrl_reg;
        if (bus_write && is_ctrl && !ctrl_locked) begin
            ctrl_next.pump_bus_clock = wr_ctrl.pump_bus_clock;
            ctrl_next.power_down = wr_ctrl.power_down;
            // Mode is frozen while the voltage is enabled
            if (!ctrl_reg.high_voltage_enable) begin
                ctrl_next.erase_mode_hi = wr_ctrl.erase_mode_hi;
                ctrl_next.erase_mode_lo = wr_ctrl.erase_mode_lo;
            end
            // Enable sets only once a valid write is captured
            if (!wr_ctrl.high_voltage_enable) begin
                ctrl_next.high_voltage_enable = 1'b0;
            end else if (ctrl_reg.bus_capture_bit && captured_reg) begin
                ctrl_next.high_voltage_enable = 1'b1;
            end
            // Capture bit cannot drop while the enable is still set
            if (ctrl_reg.high_voltage_enable) begin
                ctrl_next.bus_capture_bit = 1'b1;
            end else begin
                ctrl_next.bus_capture_bit = wr_ctrl.bus_capture_bit;
            end
        end
        // Reserved bits always read zero
        ctrl_next.rsvd6 = 1'b0;
        ctrl_next.rsvd1 = 1'b0;
    end

    // Control register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= nvm_ctrl_type'(CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ========================================================================
    // High voltage gating
    logic [1:0] cap_block;
    logic target_protected;
    logic op_allowed;

    // Redundant mode folds blocks two and three onto the lower half
    assign cap_block = redundant ? {1'b0, cap_offset_reg[BLOCK_LSB]}
                                 : cap_offset_reg[BLOCK_MSB:BLOCK_LSB];

    // Protection check by mode and target
    always_comb begin
        target_protected = 1'b0;
        op_allowed = 1'b1;
        unique case (op.mode)
            OP_BYTE_PROGRAM, OP_BYTE_ERASE: begin
                target_protected = !cap_config_reg && protect[cap_block];
            end
            OP_BLOCK_ERASE: begin
                target_protected = protect[cap_block];
                op_allowed = !cap_config_reg;
            end
            OP_BULK_ERASE: begin
                target_protected = redundant ? |protect[1:0] : |protect;
                op_allowed = !cap_config_reg;
            end
        endcase
    end

    // Power down also holds the pump off; a pulse into a
    // disabled array would leave the cells in doubt
    // Voltage on only with enable, capture bit, captured write, no protect
    assign hv_next = ctrl_reg.high_voltage_enable && ctrl_reg.bus_capture_bit
                     && captured_reg && op_allowed && !target_protected
                     && !ctrl_reg.power_down;

    // Charge pump enable and its edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_reg <= 1'b0;
            hv_prev_reg <= 1'b0;
        end else begin
            hv_reg <= hv_next;
            hv_prev_reg <= hv_reg;
        end
    end

    // ========================================================================
    // Configuration shadow
    // Reload after reset release and on each read of the config byte
    // The cells keep the byte through reset, so the shadow
    // is refreshed at the first edge after reset lets go
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_load_reg <= 1'b1;
            shadow_reg <= SHADOW_RESET;
        end else begin
            shadow_load_reg <= 1'b0;
            if (shadow_load_reg || (bus_read && is_config)) begin
                shadow_reg <= config_byte;
            end
        end
    end

    // ========================================================================
    // APB read data and answer
    // Read value assembled in the setup phase
    always_comb begin
        prdata_next = '0;
        if (is_ctrl) begin
            prdata_next[7:0] = ctrl_reg;
        end else if (is_shadow) begin
            prdata_next[CFG_REDUNDANT_BIT] = redundant;
            prdata_next[CFG_PROTECT_LSB +: BLOCKS] = protect;
        end else if (nvm_target) begin
            if (ctrl_reg.bus_capture_bit) begin
                prdata_next[7:0] = cap_data_reg;
            end else if (is_config) begin
                prdata_next[7:0] = config_byte;
            end else begin
                prdata_next[7:0] = cell_data;
            end
        end
    end

    assign pslverr_next = !mapped;

    // Ready rises for exactly one access cycle, no wait states
    // Write transfers answer with zero read data
    // One access cycle per transfer; error for unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= setup_phase;
            if (setup_phase) begin
                pslverr_reg <= pslverr_next;
                prdata_reg <= pwrite ? '0 : prdata_next;
            end else if (access_done) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Outputs
    // Bus answer straight from its registers
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // Pump and array pins straight from flip-flops
    assign high_voltage_on = hv_reg;
    assign pump_bus_clock = ctrl_reg.pump_bus_clock;
    assign array_power_down = ctrl_reg.power_down;

endmodule : nvm_program_sequencer

`default_nettype wire

// File: src/nvm_seq_pkg.sv
// Constants and types shared by the byte program sequencer and its cell array
`default_nettype none

package nvm_seq_pkg;

    // ========================================================================
    // Bus geometry
    localparam int ADDR_W = 18;
    localparam int IDX_W = 16;
    localparam int DATA_W = 32;

    // ========================================================================
    // Register and array word indexes (byte address is four times the index)
    localparam logic [IDX_W-1:0] IDX_CTRL = 16'hfe1d;
    localparam logic [IDX_W-1:0] IDX_SHADOW = 16'hfe1f;
    localparam logic [IDX_W-1:0] IDX_CONFIG = 16'hfe1c;
    localparam logic [IDX_W-1:0] IDX_ARRAY_FIRST = 16'h0800;
    localparam logic [IDX_W-1:0] IDX_ARRAY_LAST = 16'h09ff;

    // ========================================================================
    // Array geometry
    localparam int ARRAY_BYTES = 512;
    localparam int OFS_W = 9;
    localparam int HALF_BIT = 8;
    localparam int BLOCK_MSB = 8;
    localparam int BLOCK_LSB = 7;
    localparam int BLOCKS = 4;

    // ========================================================================
    // Reset and erased values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SHADOW_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] CONFIG_INIT = 8'h00;

    // ========================================================================
    // Configuration byte and shadow layout
    localparam int CFG_REDUNDANT_BIT = 7;
    localparam int CFG_PROTECT_LSB = 0;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {
        OP_BYTE_PROGRAM = 2'b00,
        OP_BYTE_ERASE = 2'b01,
        OP_BLOCK_ERASE = 2'b10,
        OP_BULK_ERASE = 2'b11
    } op_mode_type;

    typedef struct packed {
        logic pump_bus_clock;
        logic rsvd6;
        logic power_down;
        logic erase_mode_hi;
        logic erase_mode_lo;
        logic bus_capture_bit;
        logic rsvd1;
        logic high_voltage_enable;
    } nvm_ctrl_type;

    typedef struct packed {
        logic start;
        op_mode_type mode;
        logic config_sel;
        logic mirror;
        logic [OFS_W-1:0] offset;
        logic [7:0] data;
    } nvm_op_type;

endpackage : nvm_seq_pkg

`default_nettype wire

// File: tb/apb_cpu_master.sv
// CPU side bus master model issuing byte wide APB transfers
`default_nettype none

module apb_cpu_master (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [nvm_seq_pkg::ADDR_W-1:0] paddr,
    output logic [nvm_seq_pkg::DATA_W-1:0] pwdata,
    input wire logic [nvm_seq_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    import nvm_seq_pkg::*;

    // Idle bus at time zero
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= '0;
        pwdata <= '0;
    end

    // ========================================================================
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
            input logic [7:0] wdata, output logic [7:0] rdata, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, wdata};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata[7:0];
        err = pslverr;
        // Released lines show junk, not the last value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~{24'h0, wdata};
        @(posedge pclk);
    endtask : xfer

endmodule : apb_cpu_master

`default_nettype wire

// File: tb/nvm_program_sequencer_tb.sv
// Self-checking testbench for the byte program sequencer
`default_nettype none

module nvm_program_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nvm_seq_pkg::*;

    localparam logic [ADDR_W-1:0] CTRL_A = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] CFG_A = {IDX_CONFIG, 2'b00};
    localparam logic [ADDR_W-1:0] SHD_A = {IDX_SHADOW, 2'b00};

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic hv;
    logic pump;
    logic pdown;
    int err_count = 0;
    int compares = 0;

    // ========================================================================
    // Design and bus master
    nvm_program_sequencer nvm_program_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .high_voltage_on(hv), .pump_bus_clock(pump), .array_power_down(pdown)
    );
    apb_cpu_master apb_cpu_master_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ========================================================================
    // Helpers
    function automatic logic [ADDR_W-1:0] arr(input logic [8:0] ofs);
        return {IDX_ARRAY_FIRST + 16'(ofs), 2'b00};
    endfunction : arr

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb_cpu_master_i.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
            input logic [7:0] mask);
        logic [7:0] r;
        logic e;
        apb_cpu_master_i.xfer(1'b0, a, 8'h00, r, e);
        check(r & mask, exp & mask);
        check({7'h0, e}, 8'h00);
    endtask : rd_chk

    // Full capture, enable, wait, clear sequence with a decoy capture first
    task automatic do_op(input logic [7:0] mode, input logic [ADDR_W-1:0] a,
            input logic [7:0] d, input logic hv_exp);
        logic seen;
        seen = 1'b0;
        wr(CTRL_A, mode | 8'h04);
        wr(arr(9'h1ff), 8'h00);
        wr(a, d);
        rd_chk(a, d, 8'hff);
        wr(CTRL_A, mode | 8'h05);
        repeat (8) begin
            @(posedge pclk);
            seen = seen | hv;
        end
        check({7'h0, seen}, {7'h0, hv_exp});
        wr(CTRL_A, 8'h00);
        if (hv_exp) begin
            rd_chk(CTRL_A, mode | 8'h04, 8'hff);
        end
        repeat (4) @(posedge pclk);
        check({7'h0, hv}, 8'h00);
        wr(CTRL_A, 8'h00);
    endtask : do_op

    task automatic conclude();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        conclude();
    end

    // ========================================================================
    // Tests
    initial begin
        logic [7:0] r;
        logic e;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk(CTRL_A, CTRL_RESET, 8'hff);
        rd_chk(SHD_A, 8'h00, 8'h8f);
        rd_chk(arr(9'h006), ERASED_BYTE, 8'hff);
        apb_cpu_master_i.xfer(1'b0, {16'hfe1e, 2'b00}, 8'h00, r, e);
        check({7'h0, e}, 8'h01);
        // Enable refused after a non-array write
        wr(SHD_A, 8'hff);
        wr(CTRL_A, 8'h01);
        rd_chk(CTRL_A, 8'h00, 8'hff);
        // Control writes held off until a capture
        wr(CTRL_A, 8'h04);
        wr(CTRL_A, 8'h1c);
        rd_chk(CTRL_A, 8'h04, 8'hff);
        wr(arr(9'h006), 8'h55);
        wr(CTRL_A, 8'h00);
        rd_chk(arr(9'h006), ERASED_BYTE, 8'hff);
        // Reset in mid sequence discards the capture
        wr(CTRL_A, 8'h04);
        wr(arr(9'h006), 8'h00);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk(CTRL_A, 8'h00, 8'hff);
        wr(CTRL_A, 8'h04);
        wr(CTRL_A, 8'h05);
        rd_chk(CTRL_A, 8'h04, 8'hff);
        wr(arr(9'h007), 8'hff);
        wr(CTRL_A, 8'h00);
        // Program clears bits only; byte erase restores
        do_op(8'h00, arr(9'h006), 8'h3c, 1'b1);
        do_op(8'h00, arr(9'h006), 8'hf0, 1'b1);
        rd_chk(arr(9'h006), 8'h30, 8'hff);
        do_op(8'h08, arr(9'h006), 8'h00, 1'b1);
        rd_chk(arr(9'h006), ERASED_BYTE, 8'hff);
        // Protect block 0 through the configuration byte
        do_op(8'h08, CFG_A, 8'h00, 1'b1);
        do_op(8'h00, CFG_A, 8'h01, 1'b1);
        rd_chk(CFG_A, 8'h01, 8'hff);
        rd_chk(SHD_A, 8'h01, 8'h8f);
        do_op(8'h00, arr(9'h010), 8'h00, 1'b0);
        rd_chk(arr(9'h010), ERASED_BYTE, 8'hff);
        do_op(8'h00, arr(9'h090), 8'h00, 1'b1);
        rd_chk(arr(9'h090), 8'h00, 8'hff);
        // Both copies first, then redundant mode
        do_op(8'h00, arr(9'h0a0), 8'h5a, 1'b1);
        do_op(8'h00, arr(9'h1a0), 8'h5a, 1'b1);
        do_op(8'h08, CFG_A, 8'h00, 1'b1);
        do_op(8'h00, CFG_A, 8'h80, 1'b1);
        rd_chk(CFG_A, 8'h80, 8'hff);
        rd_chk(SHD_A, 8'h80, 8'h8f);
        do_op(8'h00, arr(9'h0a0), 8'h18, 1'b1);
        rd_chk(arr(9'h1a0), 8'h00, 8'hff);
        do_op(8'h08, CFG_A, 8'h00, 1'b1);
        do_op(8'h00, CFG_A, 8'h00, 1'b1);
        rd_chk(CFG_A, 8'h00, 8'hff);
        rd_chk(arr(9'h1a0), 8'h18, 8'hff);
        rd_chk(arr(9'h0a0), 8'h18, 8'hff);
        rd_chk(arr(9'h1ff), ERASED_BYTE, 8'hff);
        // Block and bulk erase
        do_op(8'h10, arr(9'h0b0), 8'h00, 1'b1);
        rd_chk(arr(9'h0a0), ERASED_BYTE, 8'hff);
        rd_chk(arr(9'h1a0), 8'h18, 8'hff);
        do_op(8'h18, arr(9'h000), 8'h00, 1'b1);
        rd_chk(arr(9'h1a0), ERASED_BYTE, 8'hff);
        // Pump clock and power down bits
        wr(CTRL_A, 8'ha0);
        check({6'h0, pump, pdown}, 8'h03);
        rd_chk(CTRL_A, 8'ha0, 8'hff);
        wr(CTRL_A, 8'h00);
        conclude();
    end

endmodule : nvm_program_sequencer_tb

`default_nettype wire

// File: tb/nvm_seq_checker.sv
// Concurrent checks on the byte program sequencer ports
`default_nettype none

module nvm_seq_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nvm_seq_pkg::ADDR_W-1:0] paddr,
    input wire logic [nvm_seq_pkg::DATA_W-1:0] pwdata,
    input wire logic [nvm_seq_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pump and array control
    input wire logic high_voltage_on,
    input wire logic pump_bus_clock,
    input wire logic array_power_down
);
    import nvm_seq_pkg::*;

    logic [IDX_W-1:0] idx;
    logic access;
    logic mapped;
    logic ctrl_wr;

    // ========================================================================
    // Transfer decode
    assign idx = paddr[ADDR_W-1:2];
    assign access = psel && penable && pready;
    assign mapped = (idx >= IDX_ARRAY_FIRST && idx <= IDX_ARRAY_LAST) || idx == IDX_CONFIG
        || idx == IDX_CTRL || idx == IDX_SHADOW;
    assign ctrl_wr = access && pwrite && idx == IDX_CTRL;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ========================================================================
    // Assertions
    rdy_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    rdy_single_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_rdy_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    err_unmapped_a: assert property (access && !mapped |-> pslverr && prdata == '0)
        else $error("unmapped access not flagged");
    no_err_mapped_a: assert property (access && mapped |-> !pslverr)
        else $error("mapped access flagged");
    data_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    hv_rise_cause_a: assert property ($rose(high_voltage_on) |-> $past(ctrl_wr && pwdata[0], 2))
        else $error("high voltage rose without enable write");
    hv_fall_bound_a: assert property (ctrl_wr && !pwdata[0] |-> ##2 !high_voltage_on)
        else $error("high voltage stayed after enable cleared");
    pins_change_cause_a: assert property ($changed({pump_bus_clock, array_power_down})
        |-> $past(ctrl_wr))
        else $error("control pin changed without control write");

endmodule : nvm_seq_checker

bind nvm_program_sequencer nvm_seq_checker nvm_seq_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_voltage_on(high_voltage_on), .pump_bus_clock(pump_bus_clock),
    .array_power_down(array_power_down)
);

`default_nettype wire
